//--- hw/dmc_mode_ctrl.sv
// device operating mode controller with its two serial registers
// Behaviour
// - sleep turns regulator off, else like standby
// - sleep keeps registers accessible with interface supply
// - sleep left by standby or normal write
// - wake or event in sleep: regulator on, standby
// - timeout watchdog reset in sleep enters reset
// - sleep write needs no pending, one source
// - filtered undervoltage forces sleep, clears wake events
// - forced sleep enables bus, both local wakes
// - sleep cause bit: zero commanded, one forced
// - normal mode still sets wake and event flags
// - normal entered only by write from standby/sleep
// - overtemperature protection works only in normal
// - prewarning sets status, enabled event signals receive
// - shutdown in normal enters overtemp, transceiver off
// - overtemp ignores new wakes, keeps pending signalled
// - overtemp exits to standby on cooling or poweroff
// - reset mode needs watchdog, ends after pulse
// - mode control holds select, upper bits zero
// - select codes sleep, standby, normal; resets standby
// - mode status read-only, low bits zero
// - prewarning status follows temperature continuously
// - normal pending set until normal first entered
// - refused sleep write goes to standby instead
// - standby write needs valid interface supply
`timescale 1ns/1ps
module dmc_mode_ctrl
   import dmc_pkg::*;
#(
   parameter int UV2SLEEP_CYCLES = UV2SLEEP_CYC,
   parameter int RESET_PULSE_CYCLES = RST_PULSE_CYC
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // serial register port pins
   input wire logic spi_sck,
   input wire logic spi_cs_n,
   input wire logic spi_sdi,
   output logic spi_sdo,
   output logic spi_sdo_oe,
   // supply monitors
   input wire logic vcc_uv,
   input wire logic vio_uv,
   input wire logic power_off,
   // temperature monitor
   input wire logic temp_prewarn,
   input wire logic temp_shutdown,
   input wire logic temp_recovered,
   // wake and event sources
   input wire logic bus_wake_det,
   input wire logic local_wake_rise,
   input wire logic local_wake_fall,
   input wire logic irq_pending,
   // watchdog
   input wire logic wdt_active,
   input wire logic wdt_timeout_mode,
   input wire logic wdt_reset,
   // wake configuration and event clearing from other registers
   input wire logic wake_cfg_wr,
   input wire logic wake_cfg_bus_en,
   input wire logic wake_cfg_rise_en,
   input wire logic wake_cfg_fall_en,
   input wire logic wake_cfg_sel_en,
   input wire logic overtemp_prewarn_irq_en,
   input wire logic [EVT_N-1:0] evt_clr,
   input wire logic [1:0] transceiver_mode_select,
   // mode outputs
   output logic regulator_enable_out,
   output logic trx_enable,
   output logic trx_off,
   output logic rxd_event_low,
   output logic [2:0] device_mode_select,
   // wake enables
   output logic bus_wake_enable,
   output logic local_wake_rise_enable,
   output logic local_wake_fall_enable,
   output logic selective_wake_enable,
   // flags
   output logic bus_wake_flag,
   output logic local_wake_rise_flag,
   output logic local_wake_fall_flag,
   output logic overtemp_prewarn_event,
   output logic overtemp_prewarn_flag,
   output logic sleep_entry_cause,
   output logic normal_pending_flag
);

   localparam logic [CNT_W-1:0] UV_LIM = CNT_W'(UV2SLEEP_CYCLES);
   localparam logic [CNT_W-1:0] RST_LIM = CNT_W'(RESET_PULSE_CYCLES - 1);

   typedef struct packed {
      dmc_mode_t mode;
      logic [CNT_W-1:0] uv_cnt;
      logic [CNT_W-1:0] rst_cnt;
      logic sleep_cause;
      logic normal_pend;
      logic prew_prev;
      logic prew_flag;
      logic [EVT_N-1:0] flags;
      logic bus_en;
      logic rise_en;
      logic fall_en;
      logic sel_en;
      logic reg_en;
      logic trx_en;
      logic trx_off;
      logic rxd_low;
      logic [2:0] mode_sel;
   } dmc_state_t;

   localparam dmc_state_t ST_RST = '{mode: DMC_STANDBY, uv_cnt: '0, rst_cnt: '0,
      sleep_cause: MODE_STAT_RST[STAT_SLEEP_CAUSE_BIT],
      normal_pend: MODE_STAT_RST[STAT_NORMAL_PEND_BIT],
      prew_prev: 1'b0, prew_flag: MODE_STAT_RST[STAT_PREWARN_BIT], flags: '0,
      bus_en: 1'b0, rise_en: 1'b0, fall_en: 1'b0, sel_en: 1'b0, reg_en: 1'b1,
      trx_en: 1'b0, trx_off: 1'b0, rxd_low: 1'b0,
      mode_sel: MODE_CTRL_RST[MODE_SEL_LSB +: MODE_SEL_W]};

   // overtemp and reset have no code of their own and read as standby
   function automatic logic [2:0] mode_code(input dmc_mode_t m);
      case (m)
         DMC_SLEEP: mode_code = MODE_SEL_SLEEP;
         DMC_NORMAL: mode_code = MODE_SEL_NORMAL;
         default: mode_code = MODE_SEL_STANDBY;
      endcase
   endfunction

   dmc_state_t s_ff;
   dmc_state_t nxt_s;
   logic [SPI_ADDR_W-1:0] reg_addr;
   logic reg_wr;
   logic [SPI_DATA_W-1:0] reg_wdata;
   logic [SPI_DATA_W-1:0] reg_rdata;

   // ==========================================================
   // serial port
   dmc_spi_port u_spi (
      .clk(clk),
      .rst(rst),
      .spi_sck(spi_sck),
      .spi_cs_n(spi_cs_n),
      .spi_sdi(spi_sdi),
      .spi_sdo(spi_sdo),
      .spi_sdo_oe(spi_sdo_oe),
      .reg_addr(reg_addr),
      .reg_wr(reg_wr),
      .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata)
   );

   always_comb begin
      case (reg_addr)
         ADDR_MODE_CTRL: reg_rdata = {5'h00, mode_code(s_ff.mode)};
         ADDR_MODE_STAT: reg_rdata = {s_ff.sleep_cause, s_ff.prew_flag,
                                      s_ff.normal_pend, 5'h00};
         default: reg_rdata = 8'h00;
      endcase
   end

   // ==========================================================
   // mode sequencing
   logic vio_ok;
   logic spi_ok;
   logic wr_mode;
   logic [2:0] sel;
   logic [EVT_N-1:0] set_vec;
   logic pending;
   logic any_src;
   logic uv_now;
   logic force_sleep;
   logic wdt_hit;

   always_comb begin
      nxt_s = s_ff;
      vio_ok = ~vio_uv;
      // interface unusable in overtemp, and in sleep without its supply
      spi_ok = (s_ff.mode != DMC_OVERTEMP) &&
               ((s_ff.mode != DMC_SLEEP) || vio_ok);
      wr_mode = reg_wr && (reg_addr == ADDR_MODE_CTRL) && spi_ok;
      sel = reg_wdata[MODE_SEL_LSB +: MODE_SEL_W];
      wdt_hit = wdt_reset && wdt_active;
      uv_now = vcc_uv || vio_uv;
      force_sleep = 1'b0;

      // event capture: new events are dropped while overheated
      set_vec[EVT_BUS] = bus_wake_det && s_ff.bus_en;
      set_vec[EVT_LW_RISE] = local_wake_rise && s_ff.rise_en;
      set_vec[EVT_LW_FALL] = local_wake_fall && s_ff.fall_en;
      set_vec[EVT_PREWARN] = temp_prewarn && !s_ff.prew_prev && overtemp_prewarn_irq_en &&
                             (s_ff.mode == DMC_NORMAL);
      if (s_ff.mode == DMC_OVERTEMP) begin
         set_vec = '0;
      end
      for (int i = 0; i < EVT_N; i++) begin
         // a set in the clearing cycle survives
         nxt_s.flags[i] = (s_ff.flags[i] && !evt_clr[i]) || set_vec[i];
      end
      pending = (|s_ff.flags) || (|set_vec) || irq_pending;
      any_src = s_ff.bus_en || s_ff.rise_en || s_ff.fall_en || s_ff.sel_en;

      if (wake_cfg_wr) begin
         nxt_s.bus_en = wake_cfg_bus_en;
         nxt_s.rise_en = wake_cfg_rise_en;
         nxt_s.fall_en = wake_cfg_fall_en;
         nxt_s.sel_en = wake_cfg_sel_en;
      end

      // undervoltage filter runs only in standby and normal
      if (((s_ff.mode == DMC_STANDBY) || (s_ff.mode == DMC_NORMAL)) && uv_now) begin
         if (s_ff.uv_cnt != UV_LIM) begin
            nxt_s.uv_cnt = s_ff.uv_cnt + 1'b1;
         end
      end else begin
         nxt_s.uv_cnt = '0;
      end

      case (s_ff.mode)
         DMC_STANDBY, DMC_NORMAL: begin
            if ((s_ff.mode == DMC_NORMAL) && temp_shutdown) begin
               nxt_s.mode = DMC_OVERTEMP;
            end else if (wdt_hit) begin
               nxt_s.mode = DMC_MCU_RESET;
               nxt_s.rst_cnt = '0;
            end else if (s_ff.uv_cnt == UV_LIM) begin
               force_sleep = 1'b1;
            end else if (wr_mode) begin
               case (sel)
                  MODE_SEL_SLEEP: begin
                     if (!pending && any_src) begin
                        nxt_s.mode = DMC_SLEEP;
                        nxt_s.sleep_cause = 1'b0;
                     end else begin
                        nxt_s.mode = DMC_STANDBY;
                     end
                  end
                  MODE_SEL_STANDBY: begin
                     if (vio_ok) begin
                        nxt_s.mode = DMC_STANDBY;
                     end
                  end
                  MODE_SEL_NORMAL: begin
                     nxt_s.mode = DMC_NORMAL;
                  end
                  default: begin
                     nxt_s.mode = s_ff.mode;
                  end
               endcase
            end
         end
         DMC_SLEEP: begin
            if (wdt_hit && wdt_timeout_mode) begin
               nxt_s.mode = DMC_MCU_RESET;
               nxt_s.rst_cnt = '0;
            end else if ((|set_vec) || irq_pending) begin
               nxt_s.mode = DMC_STANDBY;
            end else if (wr_mode && vio_ok) begin
               case (sel)
                  MODE_SEL_STANDBY: nxt_s.mode = DMC_STANDBY;
                  MODE_SEL_NORMAL: nxt_s.mode = DMC_NORMAL;
                  default: nxt_s.mode = s_ff.mode;
               endcase
            end
         end
         DMC_OVERTEMP: begin
            if (temp_recovered || power_off) begin
               nxt_s.mode = DMC_STANDBY;
            end
         end
         DMC_MCU_RESET: begin
            if (s_ff.rst_cnt >= RST_LIM) begin
               nxt_s.mode = DMC_STANDBY;
            end else begin
               nxt_s.rst_cnt = s_ff.rst_cnt + 1'b1;
            end
         end
         default: begin
            nxt_s.mode = DMC_STANDBY;
         end
      endcase

      // forced sleep wipes pending events even against a same-cycle set
      if (force_sleep) begin
         nxt_s.mode = DMC_SLEEP;
         nxt_s.flags = '0;
         nxt_s.bus_en = 1'b1;
         nxt_s.rise_en = 1'b1;
         nxt_s.fall_en = 1'b1;
         nxt_s.sel_en = 1'b0;
         nxt_s.sleep_cause = 1'b1;
      end

      if ((nxt_s.mode == DMC_NORMAL) && (s_ff.mode != DMC_NORMAL)) begin
         nxt_s.normal_pend = 1'b0;
      end
      nxt_s.prew_prev = temp_prewarn;
      nxt_s.prew_flag = temp_prewarn;

      // registered pin levels follow the next mode
      nxt_s.reg_en = (nxt_s.mode != DMC_SLEEP) &&
                     (nxt_s.mode != DMC_MCU_RESET);
      nxt_s.trx_en = (nxt_s.mode == DMC_NORMAL);
      nxt_s.trx_off = (nxt_s.mode == DMC_OVERTEMP) ||
                      (nxt_s.mode == DMC_MCU_RESET);
      // receive line carries bus data in normal unless transceiver is in standby
      nxt_s.rxd_low = ((|nxt_s.flags) || irq_pending) &&
                      ((nxt_s.mode != DMC_NORMAL) ||
                       (transceiver_mode_select == TRX_SEL_STANDBY));
      nxt_s.mode_sel = mode_code(nxt_s.mode);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_ff <= ST_RST;
      end else begin
         s_ff <= nxt_s;
      end
   end

   // ==========================================================
   // outputs
   assign regulator_enable_out = s_ff.reg_en;
   assign trx_enable = s_ff.trx_en;
   assign trx_off = s_ff.trx_off;
   assign rxd_event_low = s_ff.rxd_low;
   assign device_mode_select = s_ff.mode_sel;
   assign bus_wake_enable = s_ff.bus_en;
   assign local_wake_rise_enable = s_ff.rise_en;
   assign local_wake_fall_enable = s_ff.fall_en;
   assign selective_wake_enable = s_ff.sel_en;
   assign bus_wake_flag = s_ff.flags[EVT_BUS];
   assign local_wake_rise_flag = s_ff.flags[EVT_LW_RISE];
   assign local_wake_fall_flag = s_ff.flags[EVT_LW_FALL];
   assign overtemp_prewarn_event = s_ff.flags[EVT_PREWARN];
   assign overtemp_prewarn_flag = s_ff.prew_flag;
   assign sleep_entry_cause = s_ff.sleep_cause;
   assign normal_pending_flag = s_ff.normal_pend;

endmodule // dmc_mode_ctrl

//--- hw/dmc_pkg.sv
// package of constants and types for the device mode controller
package dmc_pkg;

   // ==========================================================
   // register map
   localparam logic [6:0] ADDR_MODE_CTRL = 7'h01;
   localparam logic [6:0] ADDR_MODE_STAT = 7'h03;
   localparam logic [7:0] MODE_CTRL_RST = 8'h04;
   localparam logic [7:0] MODE_STAT_RST = 8'h20;
   localparam int MODE_SEL_LSB = 0;
   localparam int MODE_SEL_W = 3;
   localparam int STAT_SLEEP_CAUSE_BIT = 7;
   localparam int STAT_PREWARN_BIT = 6;
   localparam int STAT_NORMAL_PEND_BIT = 5;

   // ==========================================================
   // device mode select codes
   localparam logic [2:0] MODE_SEL_SLEEP = 3'h1;
   localparam logic [2:0] MODE_SEL_STANDBY = 3'h4;
   localparam logic [2:0] MODE_SEL_NORMAL = 3'h7;
   localparam logic [1:0] TRX_SEL_STANDBY = 2'h0;

   // ==========================================================
   // event flag positions
   localparam int EVT_N = 4;
   localparam int EVT_BUS = 0;
   localparam int EVT_LW_RISE = 1;
   localparam int EVT_LW_FALL = 2;
   localparam int EVT_PREWARN = 3;

   // ==========================================================
   // timing
   localparam int CLK_PERIOD_NS = 5;
   localparam int UV2SLEEP_NS = 1000000;
   localparam int RST_PULSE_NS = 20000;
   localparam int UV2SLEEP_CYC = (UV2SLEEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RST_PULSE_CYC = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 24;

   // ==========================================================
   // serial port framing
   localparam int SPI_ADDR_W = 7;
   localparam int SPI_DATA_W = 8;
   localparam logic [4:0] SPI_ADDR_LAST = 5'h06;
   localparam logic [4:0] SPI_RW_BIT = 5'h07;
   localparam logic [4:0] SPI_DATA_FIRST = 5'h08;
   localparam logic [4:0] SPI_FRAME_LAST = 5'h0f;

   typedef enum logic [2:0] {
      DMC_STANDBY,
      DMC_NORMAL,
      DMC_SLEEP,
      DMC_OVERTEMP,
      DMC_MCU_RESET
   } dmc_mode_t;

endpackage

//--- hw/dmc_spi_port.sv
// serial register port: pins sampled by the system clock
`timescale 1ns/1ps
module dmc_spi_port
   import dmc_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // pins
   input wire logic spi_sck,
   input wire logic spi_cs_n,
   input wire logic spi_sdi,
   output logic spi_sdo,
   output logic spi_sdo_oe,
   // register side
   output logic [SPI_ADDR_W-1:0] reg_addr,
   output logic reg_wr,
   output logic [SPI_DATA_W-1:0] reg_wdata,
   input wire logic [SPI_DATA_W-1:0] reg_rdata
);

   typedef struct packed {
      logic sck_s1;
      logic sck_s2;
      logic sck_s3;
      logic cs_s1;
      logic cs_s2;
      logic sdi_s1;
      logic sdi_s2;
      logic [4:0] bit_cnt;
      logic rw_read;
      logic [SPI_DATA_W-1:0] in_sh;
      logic [SPI_DATA_W-1:0] out_sh;
      logic [SPI_ADDR_W-1:0] addr;
      logic [SPI_DATA_W-1:0] wdata;
      logic wr;
      logic sdo;
      logic sdo_oe;
   } dmc_spi_st_t;

   localparam dmc_spi_st_t SPI_RST = '{sck_s1: 1'b0, sck_s2: 1'b0, sck_s3: 1'b0,
      cs_s1: 1'b1, cs_s2: 1'b1, sdi_s1: 1'b0, sdi_s2: 1'b0, bit_cnt: 5'h00,
      rw_read: 1'b0, in_sh: 8'h00, out_sh: 8'h00, addr: 7'h00, wdata: 8'h00,
      wr: 1'b0, sdo: 1'b0, sdo_oe: 1'b0};

   dmc_spi_st_t s_ff;
   dmc_spi_st_t nxt_s;
   logic rise;
   logic fall;

   always_comb begin
      nxt_s = s_ff;
      // first stages feed only the second stages
      nxt_s.sck_s1 = spi_sck;
      nxt_s.sck_s2 = s_ff.sck_s1;
      nxt_s.sck_s3 = s_ff.sck_s2;
      nxt_s.cs_s1 = spi_cs_n;
      nxt_s.cs_s2 = s_ff.cs_s1;
      nxt_s.sdi_s1 = spi_sdi;
      nxt_s.sdi_s2 = s_ff.sdi_s1;
      nxt_s.wr = 1'b0;
      rise = s_ff.sck_s2 & ~s_ff.sck_s3;
      fall = ~s_ff.sck_s2 & s_ff.sck_s3;
      if (s_ff.cs_s2) begin
         nxt_s.bit_cnt = 5'h00;
         nxt_s.sdo_oe = 1'b0;
         nxt_s.sdo = 1'b0;
      end else begin
         nxt_s.sdo_oe = 1'b1;
         if (rise) begin
            nxt_s.in_sh = {s_ff.in_sh[SPI_DATA_W-2:0], s_ff.sdi_s2};
            nxt_s.bit_cnt = s_ff.bit_cnt + 5'h01;
            if (s_ff.bit_cnt == SPI_ADDR_LAST) begin
               nxt_s.addr = {s_ff.in_sh[SPI_ADDR_W-2:0], s_ff.sdi_s2};
            end
            if (s_ff.bit_cnt == SPI_RW_BIT) begin
               nxt_s.rw_read = s_ff.sdi_s2;
               // read data must sit on the pin before the next rising edge
               nxt_s.sdo = reg_rdata[SPI_DATA_W-1];
               nxt_s.out_sh = {reg_rdata[SPI_DATA_W-2:0], 1'b0};
            end
            if (s_ff.bit_cnt == SPI_FRAME_LAST) begin
               nxt_s.wr = ~s_ff.rw_read;
               nxt_s.wdata = {s_ff.in_sh[SPI_DATA_W-2:0], s_ff.sdi_s2};
               nxt_s.bit_cnt = 5'h00;
            end
         end else if (fall && (s_ff.bit_cnt > SPI_DATA_FIRST)) begin
            nxt_s.sdo = s_ff.out_sh[SPI_DATA_W-1];
            nxt_s.out_sh = {s_ff.out_sh[SPI_DATA_W-2:0], 1'b0};
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_ff <= SPI_RST;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign spi_sdo = s_ff.sdo;
   assign spi_sdo_oe = s_ff.sdo_oe;
   assign reg_addr = s_ff.addr;
   assign reg_wr = s_ff.wr;
   assign reg_wdata = s_ff.wdata;

endmodule // dmc_spi_port

//--- verification/dmc_mode_ctrl_sva.sv
// port checker for the device mode controller
`timescale 1ns/1ps
module dmc_mode_ctrl_sva (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // causes
   input wire logic temp_prewarn,
   input wire logic temp_shutdown,
   input wire logic irq_pending,
   input wire logic wdt_reset,
   // mode and flags
   input wire logic regulator_enable_out,
   input wire logic trx_enable,
   input wire logic trx_off,
   input wire logic rxd_event_low,
   input wire logic [2:0] device_mode_select,
   input wire logic bus_wake_enable,
   input wire logic local_wake_rise_enable,
   input wire logic local_wake_fall_enable,
   input wire logic selective_wake_enable,
   input wire logic bus_wake_flag,
   input wire logic overtemp_prewarn_flag,
   input wire logic sleep_entry_cause,
   input wire logic normal_pending_flag
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // ==========================================================
   // mode rules
   sleep_reg_off_a: assert property (
      device_mode_select == 3'h1 |-> !regulator_enable_out) else $error("regulator on in sleep");
   normal_code_a: assert property (
      trx_enable |-> device_mode_select == 3'h7) else $error("transceiver on outside normal");
   code_legal_a: assert property (
      device_mode_select inside {3'h1, 3'h4, 3'h7}) else $error("illegal mode code");
   pend_clear_a: assert property (
      $rose(trx_enable) |-> !normal_pending_flag) else $error("pending kept after normal");
   pend_stays_a: assert property (
      !normal_pending_flag |=> !normal_pending_flag) else $error("pending set again");
   prewarn_follow_a: assert property (
      !$past(rst) |-> overtemp_prewarn_flag == $past(temp_prewarn)) else $error("prewarn lag");
   forced_enables_a: assert property (
      $rose(sleep_entry_cause) |-> bus_wake_enable && local_wake_rise_enable
         && local_wake_fall_enable && !selective_wake_enable) else $error("forced enables");
   forced_clear_a: assert property (
      $rose(sleep_entry_cause) |-> !bus_wake_flag && device_mode_select == 3'h1)
      else $error("forced sleep entry");
   shutdown_a: assert property (
      trx_enable && temp_shutdown |=> trx_off && !trx_enable) else $error("no overtemp entry");
   otemp_gate_a: assert property (
      !trx_enable && !trx_off && temp_shutdown && !wdt_reset |=> !trx_off)
      else $error("overtemp outside normal");
   sleep_wake_a: assert property (
      device_mode_select == 3'h1 && irq_pending && !wdt_reset
         |=> device_mode_select == 3'h4 && regulator_enable_out) else $error("no wake");
   otemp_rxd_a: assert property (
      trx_off && irq_pending |=> rxd_event_low) else $error("pending not signalled");
   cover property ($rose(sleep_entry_cause));
   cover property ($rose(trx_off));
   cover property ($rose(trx_enable));
endmodule // dmc_mode_ctrl_sva

bind dmc_mode_ctrl dmc_mode_ctrl_sva dmc_mode_ctrl_sva_inst (.*);

//--- verification/dmc_spi_host.sv
// host model driving the serial register port
`timescale 1ns/1ps
module dmc_spi_host (
   // clock
   input wire logic clk,
   // pins
   output logic spi_sck,
   output logic spi_cs_n,
   output logic spi_sdi,
   input wire logic spi_sdo,
   // read result
   output logic [7:0] rd_data,
   output logic rd_valid
);
   initial begin
      spi_sck = 1'b0;
      spi_cs_n = 1'b1;
      spi_sdi = 1'b0;
      rd_data = 8'h00;
      rd_valid = 1'b0;
   end
   // ==========================================================
   // one frame, msb first; sck rests low between frames
   task automatic xfer(input logic [6:0] a, input logic rd, input logic [7:0] wd);
      logic [15:0] f;
      logic [7:0] r;
      f = {a, rd, wd};
      r = 8'h00;
      @(posedge clk);
      spi_cs_n <= 1'b0;
      for (int i = 15; i >= 0; i--) begin
         spi_sdi <= f[i];
         repeat (8) @(posedge clk);
         spi_sck <= 1'b1;
         repeat (8) @(posedge clk);
         // data bits ride the last eight pulses, one bit per high phase
         if (i <= 7) r[i] = spi_sdo;
         spi_sck <= 1'b0;
      end
      repeat (8) @(posedge clk);
      spi_cs_n <= 1'b1;
      // released line flips so a stale bit never looks like data
      spi_sdi <= ~f[0];
      rd_data <= r;
      rd_valid <= rd;
      @(posedge clk);
      rd_valid <= 1'b0;
      repeat (6) @(posedge clk);
   endtask
endmodule // dmc_spi_host

//--- verification/dmc_mode_ctrl_tb.sv
// self-checking testbench for the device mode controller
`timescale 1ns/1ps
module dmc_mode_ctrl_tb;
   localparam int UV_CYC = 20;
   localparam int RP_CYC = 10;
   logic clk, rst, spi_sck, spi_cs_n, spi_sdi, spi_sdo, spi_sdo_oe;
   logic vcc_uv, vio_uv, power_off, temp_prewarn, temp_shutdown, temp_recovered;
   logic bus_wake_det, local_wake_rise, local_wake_fall, irq_pending;
   logic wdt_active, wdt_timeout_mode, wdt_reset, wake_cfg_wr, wake_cfg_bus_en;
   logic wake_cfg_rise_en, wake_cfg_fall_en, wake_cfg_sel_en, overtemp_prewarn_irq_en;
   logic [3:0] evt_clr;
   logic [1:0] transceiver_mode_select;
   logic regulator_enable_out, trx_enable, trx_off, rxd_event_low;
   logic [2:0] device_mode_select;
   logic bus_wake_enable, local_wake_rise_enable, local_wake_fall_enable;
   logic selective_wake_enable, bus_wake_flag, local_wake_rise_flag;
   logic local_wake_fall_flag, overtemp_prewarn_event, overtemp_prewarn_flag;
   logic sleep_entry_cause, normal_pending_flag, rd_valid;
   logic [7:0] rd_data;
   logic [7:0] exp_q[$];
   logic [31:0] seed = 32'h0b5d_5ddd;
   logic [2:0] bad_code[5] = '{3'h0, 3'h2, 3'h3, 3'h5, 3'h6};
   int n_errors = 0;
   int comparisons = 0;

   dmc_mode_ctrl #(.UV2SLEEP_CYCLES(UV_CYC), .RESET_PULSE_CYCLES(RP_CYC)) dmc_mode_ctrl_inst (.*);
   dmc_spi_host dmc_spi_host_inst (.*);

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // ==========================================================
   // helpers
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic check(input logic [7:0] seen, input logic [7:0] want);
      comparisons++;
      if (seen !== want) begin
         n_errors++;
         $display("MISMATCH t=%0t seen %h want %h", $time, seen, want);
      end
   endtask
   task automatic flag(input logic seen, input logic want);
      check({7'h00, seen}, {7'h00, want});
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      dmc_spi_host_inst.xfer(a, 1'b0, d);
   endtask
   task automatic rd(input logic [6:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      dmc_spi_host_inst.xfer(a, 1'b1, 8'h00);
   endtask
   task automatic wrap_up;
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      if (rd_valid === 1'b1) check(rd_data, exp_q.pop_front());
   end
   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      wrap_up();
   end
   // ==========================================================
   // scenarios
   initial begin
      {vcc_uv, vio_uv, power_off, temp_prewarn, temp_shutdown, temp_recovered} = '0;
      {bus_wake_det, local_wake_rise, local_wake_fall, irq_pending, wdt_active} = '0;
      {wdt_timeout_mode, wdt_reset, wake_cfg_wr, wake_cfg_bus_en, wake_cfg_rise_en} = '0;
      {wake_cfg_fall_en, wake_cfg_sel_en, overtemp_prewarn_irq_en} = '0;
      evt_clr = 4'h0;
      transceiver_mode_select = 2'h0;
      rst = 1'b1;
      tick(10);
      rst <= 1'b0;
      tick(4);
      flag(spi_sdo_oe, 1'b0);
      rd(7'h01, 8'h04);
      rd(7'h03, 8'h20);
      rd(7'h02, 8'h00);
      wr(7'h01, 8'h01);
      rd(7'h01, 8'h04);
      wr(7'h01, 8'h07);
      flag(trx_enable, 1'b1);
      rd(7'h03, 8'h00);
      for (int i = 0; i < 3; i++) begin
         seed = lfsr(seed);
         wr(7'h01, {seed[7:3], bad_code[seed[15:8] % 5]});
      end
      rd(7'h01, 8'h07);
      wr(7'h03, 8'hff);
      rd(7'h03, 8'h00);
      // bus wake is only captured once its enable is loaded
      {wake_cfg_wr, wake_cfg_bus_en, wake_cfg_sel_en} <= 3'h7;
      tick(1);
      wake_cfg_wr <= 1'b0;
      bus_wake_det <= 1'b1;
      overtemp_prewarn_irq_en <= 1'b1;
      temp_prewarn <= 1'b1;
      tick(1);
      bus_wake_det <= 1'b0;
      tick(3);
      flag(bus_wake_flag, 1'b1);
      flag(overtemp_prewarn_event, 1'b1);
      rd(7'h03, 8'h40);
      temp_prewarn <= 1'b0;
      evt_clr <= 4'h9;
      tick(1);
      evt_clr <= 4'h0;
      rd(7'h03, 8'h00);
      wr(7'h01, 8'h01);
      flag(regulator_enable_out, 1'b0);
      rd(7'h01, 8'h01);
      rd(7'h03, 8'h00);
      irq_pending <= 1'b1;
      tick(3);
      flag(regulator_enable_out, 1'b1);
      check({5'h00, device_mode_select}, 8'h04);
      irq_pending <= 1'b0;
      wr(7'h01, 8'h01);
      wr(7'h01, 8'h07);
      rd(7'h01, 8'h07);
      irq_pending <= 1'b1;
      temp_shutdown <= 1'b1;
      tick(3);
      flag(trx_off, 1'b1);
      flag(rxd_event_low, 1'b1);
      {irq_pending, temp_shutdown, temp_recovered} <= 3'h1;
      tick(3);
      temp_recovered <= 1'b0;
      rd(7'h01, 8'h04);
      temp_shutdown <= 1'b1;
      tick(3);
      flag(trx_off, 1'b0);
      temp_shutdown <= 1'b0;
      vio_uv <= 1'b1;
      tick(UV_CYC + 5);
      vio_uv <= 1'b0;
      tick(2);
      check({5'h00, device_mode_select}, 8'h01);
      check({4'h0, bus_wake_enable, local_wake_rise_enable, local_wake_fall_enable,
         selective_wake_enable}, 8'h0e);
      rd(7'h03, 8'h80);
      {wdt_active, wdt_timeout_mode, wdt_reset} <= 3'h7;
      tick(1);
      wdt_reset <= 1'b0;
      tick(3);
      flag(trx_off, 1'b1);
      tick(RP_CYC + 4);
      flag(regulator_enable_out, 1'b1);
      check({5'h00, device_mode_select}, 8'h04);
      {local_wake_rise, local_wake_fall} <= 2'h3;
      tick(1);
      {local_wake_rise, local_wake_fall} <= 2'h0;
      tick(2);
      check({6'h00, local_wake_rise_flag, local_wake_fall_flag}, 8'h03);
      wrap_up();
   end
endmodule // dmc_mode_ctrl_tb
